/* File: door_cmd_cfg.svh */
// constants for the door command mask and light barrier block
`ifndef DOOR_CMD_CFG_SVH
`define DOOR_CMD_CFG_SVH
`define OFS_FIELDBUS_MASK 12'h000
`define OFS_FUNCTION_BLOCK_LOGIC_MASK 12'h004
`define OFS_CONTROL 12'h008
`define OFS_RANGE 12'h00C
`define OFS_STATUS 12'h010
`define OFS_EFFECTIVE 12'h014
`define MASK_RESET 16'hFFFF
`define LOW_BYTE_ONES 8'hFF
`define LOW_BYTE_ZERO 8'h00
`define EXT_SECOND_PROFILE 10
`define EXT_BARRIER 15
`define CMD_STOP 8'h01
`define CMD_OPEN 8'h02
`define CMD_CLOSE 8'h03
`define RANGE_RESET 16'hFFFF
`define MIN_OPENING_MM 16'h000A
`define CTRL_TEST_RUN 0
`define CTRL_BUS_SOURCE 1
`define CTRL_CMD_STROBE 2
`define CTRL_MODE_LSB 4
`define CTRL_SENSOR_LSB 8
`define CTRL_FOLLOW_LSB 12
`endif

/* File: door_cmd_pkg.sv */
// types for the door command mask and light barrier block
package door_cmd_pkg;
	typedef enum logic [2:0] {
		mode_learn = 3'b000,
		mode_initial = 3'b001,
		mode_normal = 3'b011,
		mode_position = 3'b010,
		mode_special = 3'b110
	} sys_mode_type;
	typedef enum logic [1:0] {
		sensor_none = 2'b00,
		sensor_end_position = 2'b01,
		sensor_curtain = 2'b11,
		sensor_edge = 2'b10
	} sensor_type;
	typedef enum logic [2:0] {
		react_none = 3'b000,
		react_reverse = 3'b001,
		react_ramp_stop = 3'b011,
		react_deenergize = 3'b010,
		react_follow_up = 3'b110
	} reaction_type;
endpackage

/* File: door_mask_reg.sv */
// one 16-bit command mask register with low byte correction
`timescale 1ns/1ns
`default_nettype none
`include "door_cmd_cfg.svh"
module door_mask_reg (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// write port
	input wire logic wr_en,
	input wire logic [15:0] wr_data,
	// stored mask
	output logic [15:0] mask_q
);
	logic [7:0] low_byte;

	// the low byte is a numeric code, so partial masks make no sense
	always_comb begin
		if (wr_data[7:0] == `LOW_BYTE_ZERO)
			low_byte = `LOW_BYTE_ZERO;
		else
			low_byte = `LOW_BYTE_ONES; // (R03)
	end

	always_ff @(posedge clock) begin
		if (srst)
			mask_q <= `MASK_RESET; // (R01)
		else if (wr_en)
			mask_q <= {wr_data[15:8], low_byte};
	end
endmodule
`default_nettype wire

/* File: door_cmd_mask.sv */
// door command masking, test run and light barrier evaluation
`timescale 1ns/1ns
`default_nettype none
`include "door_cmd_cfg.svh"
// Functional notes
// (R01) fieldbus word passes where fieldbus mask is one
// (R02) function block word uses its own mask
// (R03) low byte mask writes forced to 00 or FF
// (R04) test run skips reversing once, then clears
// (R05) test run keeps force until next command
// (R06) low barrier means interrupted, blocks closing
// (R07) interruption during close drives door open
// (R08) barrier ignored below one centimetre opening
// (R09) barrier used only in operation state
// (R10) barrier low active, not function tested
// (R11) barrier reaction limited by reaction range
// (R12) learn run interruption cancels and deenergizes
// (R13) initial or special mode ramps to stop
// (R14) normal reverses, follow-up order, positioning stops
// (R15) curtain sensor type drives sensor test output
// (R16) input 1 has one exclusive sensor function
// (R17) curtain output honoured only inside range
// (R18) extension bit 10 selects second force profile
// (R19) effective word is input AND mask
module door_cmd_mask
	import door_cmd_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// command sources
	input wire logic [15:0] fieldbus_command_word,
	input wire logic [15:0] function_block_logic,
	input wire logic cmd_valid,
	// controller state
	input wire logic operation_state,
	input wire logic [15:0] door_opening_mm,
	input wire logic [15:0] dist_to_closed_mm,
	input wire logic obstruction,
	input wire logic reversing,
	// sensor pins
	input wire logic input1_pin,
	input wire logic test_pulse,
	// results
	output logic [15:0] effective_cmd,
	output logic [7:0] door_command_code,
	output logic second_force_profile,
	output logic close_allowed,
	output logic drive_open,
	output logic ramp_stop,
	output logic deenergize,
	output logic learn_cancel,
	output logic follow_up_active,
	output logic hold_force,
	output logic test_run_active,
	output logic sensor_test_output
);
	logic [1:0] pin_sync_q;
	logic [15:0] fb_mask_q;
	logic [15:0] fblk_mask_q;
	logic [15:0] range_q;
	logic [15:0] ctrl_q;
	logic test_arm_q;
	logic test_used_q;
	logic [15:0] eff_d;
	logic barrier_bit;
	logic curtain_ok;
	logic interrupted;
	logic in_range;
	logic closing;
	logic wr;
	logic rd;
	logic known;
	reaction_type react;
	sys_mode_type mode;
	sensor_type sens;

	function automatic logic [15:0] apply_mask(input logic [15:0] w,
		input logic [15:0] m);
		apply_mask = w & m; // (R19)
	endfunction

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction

	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign known = hit(paddr, `OFS_FIELDBUS_MASK) ||
		hit(paddr, `OFS_FUNCTION_BLOCK_LOGIC_MASK) || hit(paddr, `OFS_CONTROL) ||
		hit(paddr, `OFS_RANGE) || hit(paddr, `OFS_STATUS) ||
		hit(paddr, `OFS_EFFECTIVE);
	assign mode = sys_mode_type'(ctrl_q[`CTRL_MODE_LSB +: 3]);
	assign sens = sensor_type'(ctrl_q[`CTRL_SENSOR_LSB +: 2]); // (R16)

	door_mask_reg fieldbus_mask (
		.clock(clock),
		.srst(srst),
		.wr_en(wr && hit(paddr, `OFS_FIELDBUS_MASK)),
		.wr_data(pwdata[15:0]),
		.mask_q(fb_mask_q)
	);

	door_mask_reg function_block_logic_mask (
		.clock(clock),
		.srst(srst),
		.wr_en(wr && hit(paddr, `OFS_FUNCTION_BLOCK_LOGIC_MASK)),
		.wr_data(pwdata[15:0]),
		.mask_q(fblk_mask_q)
	);

	// pin passes two flops before use
	always_ff @(posedge clock) begin
		if (srst)
			pin_sync_q <= 2'b11;
		else
			pin_sync_q <= {pin_sync_q[0], input1_pin};
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl_q <= 16'h0000;
			range_q <= `RANGE_RESET;
		end else if (wr && hit(paddr, `OFS_CONTROL)) begin
			ctrl_q <= pwdata[15:0];
		end else if (wr && hit(paddr, `OFS_RANGE)) begin
			range_q <= pwdata[15:0];
		end
	end

	// one cycle access phase, zero wait states
	always_ff @(posedge clock) begin
		if (srst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !known;
			if (rd) begin
				case (paddr)
				`OFS_FIELDBUS_MASK: prdata <= {16'h0000, fb_mask_q};
				`OFS_FUNCTION_BLOCK_LOGIC_MASK: prdata <= {16'h0000, fblk_mask_q};
				`OFS_CONTROL: prdata <= {16'h0000, ctrl_q};
				`OFS_RANGE: prdata <= {16'h0000, range_q};
				`OFS_STATUS: prdata <= {28'h0000000, interrupted,
					close_allowed, test_used_q, test_arm_q};
				`OFS_EFFECTIVE: prdata <= {16'h0000, effective_cmd};
				default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// source select and masking
	always_comb begin
		if (ctrl_q[`CTRL_BUS_SOURCE])
			eff_d = apply_mask(fieldbus_command_word, fb_mask_q); // (R01)
		else
			eff_d = apply_mask(function_block_logic, fblk_mask_q); // (R02)
	end

	// outside operation the barrier rests at its clear value
	assign barrier_bit = operation_state ?
		eff_d[`EXT_BARRIER] : 1'b1; // (R09)
	// curtain safety output also low active; only valid as curtain type
	assign curtain_ok = (sens != sensor_curtain) || pin_sync_q[1]; // (R16)
	assign in_range = dist_to_closed_mm <= range_q; // (R11) (R17)
	// bit is never part of the function test, so no test masking here
	assign interrupted = (!barrier_bit || !curtain_ok) && in_range &&
		(door_opening_mm >= `MIN_OPENING_MM); // (R06) (R08) (R10)
	assign closing = (eff_d[7:0] == `CMD_CLOSE);

	// reaction per mode; test run suppresses the reversing
	always_comb begin
		react = react_none;
		if (interrupted && mode == mode_learn)
			react = react_deenergize; // (R12)
		else if (interrupted && closing) begin // (R07)
			case (mode)
			mode_initial: react = react_ramp_stop; // (R13)
			mode_special: react = react_ramp_stop; // (R13)
			mode_position: react = react_ramp_stop; // (R14)
			mode_normal: begin
				if (test_arm_q)
					react = react_none; // (R04)
				else if (reversing && obstruction)
					react = react_follow_up; // (R14)
				else
					react = react_reverse; // (R14)
			end
			default: react = react_none;
			endcase
		end
	end

	// test run: arm by write, marked used by the next command, cleared by the one after
	always_ff @(posedge clock) begin
		if (srst) begin
			test_arm_q <= 1'b0;
			test_used_q <= 1'b0;
		end else if (wr && hit(paddr, `OFS_CONTROL) &&
			pwdata[`CTRL_TEST_RUN]) begin
			test_arm_q <= 1'b1;
			test_used_q <= 1'b0;
		end else if (cmd_valid && test_arm_q && !test_used_q) begin
			test_used_q <= 1'b1; // (R04)
		end else if (cmd_valid && test_used_q) begin
			test_arm_q <= 1'b0; // (R04)
			test_used_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			effective_cmd <= 16'h0000;
			door_command_code <= `LOW_BYTE_ZERO;
			second_force_profile <= 1'b0;
			close_allowed <= 1'b0;
			drive_open <= 1'b0;
			ramp_stop <= 1'b0;
			deenergize <= 1'b0;
			learn_cancel <= 1'b0;
			follow_up_active <= 1'b0;
			test_run_active <= 1'b0;
			sensor_test_output <= 1'b0;
		end else begin
			effective_cmd <= eff_d; // (R19)
			door_command_code <= eff_d[7:0];
			second_force_profile <= eff_d[`EXT_SECOND_PROFILE]; // (R18)
			close_allowed <= !interrupted; // (R06)
			drive_open <= react == react_reverse; // (R07) (R14)
			ramp_stop <= react == react_ramp_stop; // (R13)
			deenergize <= react == react_deenergize; // (R12)
			learn_cancel <= react == react_deenergize; // (R12)
			follow_up_active <= react == react_follow_up; // (R14)
			test_run_active <= test_arm_q; // (R04)
			sensor_test_output <= (sens == sensor_curtain) &&
				test_pulse; // (R15)
		end
	end

	// during a test run force persists through an obstruction until a new command
	always_ff @(posedge clock) begin
		if (srst)
			hold_force <= 1'b0;
		else if (test_arm_q && obstruction)
			hold_force <= 1'b1; // (R05)
		else if (cmd_valid)
			hold_force <= 1'b0; // (R05)
	end

	logic unused_ok;
	assign unused_ok = ^{ctrl_q[`CTRL_FOLLOW_LSB +: 4],
		ctrl_q[`CTRL_CMD_STROBE], ctrl_q[3], ctrl_q[7], ctrl_q[11:10]};
endmodule
`default_nettype wire

/* File: door_cmd_mask_checker.sv */
// port assertions for the door command block
`timescale 1ns/1ns
`default_nettype none
module door_cmd_mask_checker (
	// clock, reset and bus answer
	input wire logic clock,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// command words and results
	input wire logic [15:0] fieldbus_command_word,
	input wire logic [15:0] function_block_logic,
	input wire logic [15:0] effective_cmd,
	input wire logic [7:0] door_command_code,
	input wire logic second_force_profile,
	input wire logic drive_open,
	input wire logic ramp_stop,
	input wire logic deenergize,
	input wire logic learn_cancel,
	input wire logic test_pulse,
	input wire logic sensor_test_output
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		psel && penable && pready;
	endsequence
	a_apb_zero_wait: assert property (s_setup |=> s_answer)
		else $error("access phase not answered at once");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_error_paired: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_masked_subset: assert property ((effective_cmd &
		~($past(fieldbus_command_word) | $past(function_block_logic)))
		== 16'h0000) else $error("effective bit not in any source word");
	a_code_low: assert property (door_command_code == effective_cmd[7:0])
		else $error("command code differs from masked low byte");
	a_profile_bit: assert property (second_force_profile == effective_cmd[10])
		else $error("second profile differs from bit 10");
	a_one_reaction: assert property ($onehot0({drive_open, ramp_stop, deenergize}))
		else $error("more than one barrier reaction");
	a_learn_off: assert property (learn_cancel |-> deenergize)
		else $error("learn cancel without deenergize");
	a_test_copy: assert property (sensor_test_output |->
		$past(test_pulse) || $past(test_pulse, 2))
		else $error("test output high without test pulse");
endmodule
bind door_cmd_mask door_cmd_mask_checker u_chk (
	.clock(clock),
	.srst(srst),
	.psel(psel),
	.penable(penable),
	.pready(pready),
	.pslverr(pslverr),
	.fieldbus_command_word(fieldbus_command_word),
	.function_block_logic(function_block_logic),
	.effective_cmd(effective_cmd),
	.door_command_code(door_command_code),
	.second_force_profile(second_force_profile),
	.drive_open(drive_open),
	.ramp_stop(ramp_stop),
	.deenergize(deenergize),
	.learn_cancel(learn_cancel),
	.test_pulse(test_pulse),
	.sensor_test_output(sensor_test_output)
);
`default_nettype wire

/* File: fieldbus_master_model.sv */
// plc fieldbus master sending door command words
`timescale 1ns/1ns
`default_nettype none
module fieldbus_master_model (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// request from bench
	input wire logic send,
	input wire logic slow,
	input wire logic barrier_clear,
	input wire logic [14:0] cmd,
	// fieldbus side
	output logic [15:0] fieldbus_command_word,
	output logic cmd_valid
);
	logic due_q;
	// word is process data, so it stands as a level between commands
	always_ff @(posedge clock) begin
		if (srst) begin
			fieldbus_command_word <= 16'h8000;
			cmd_valid <= 1'b0;
			due_q <= 1'b0;
		end else begin
			if (send) fieldbus_command_word <= {barrier_clear, cmd};
			due_q <= send && slow;
			cmd_valid <= (send && !slow) || due_q;
		end
	end
endmodule
`default_nettype wire

/* File: test_door_command_mask_and_light_barrier.sv */
// self-checking bench for the door command block
`timescale 1ns/1ns
`default_nettype none
`include "door_cmd_cfg.svh"
module test_door_command_mask_and_light_barrier;
	logic clock, srst, psel, penable, pwrite, pready, pslverr, cmd_valid;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, v;
	logic [15:0] fieldbus_command_word, function_block_logic, effective_cmd;
	logic [15:0] door_opening_mm, dist_to_closed_mm, w, m;
	logic operation_state, obstruction, reversing, input1_pin, test_pulse;
	logic [7:0] door_command_code;
	logic second_force_profile, close_allowed, drive_open, ramp_stop;
	logic deenergize, learn_cancel, follow_up_active, hold_force, e;
	logic test_run_active, sensor_test_output, send, slow, barrier_clear;
	logic [14:0] cmd;
	int err_total, n_checks, cyc;
	door_cmd_mask u_dut (.*);
	fieldbus_master_model u_plc (.*);
	initial begin
		clock = 0;
		forever #5 clock = ~clock;
	end
	task conclude;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			conclude;
		end
	end
	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", nm, x, g);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task send_cmd(input logic [15:0] x);
		@(posedge clock);
		cmd <= x[14:0]; barrier_clear <= x[15]; function_block_logic <= x;
		send <= 1; slow <= $urandom;
		@(posedge clock);
		send <= 0;
		repeat (5) @(posedge clock);
	endtask
	function automatic logic [15:0] fix(input logic [15:0] x);
		return (x[7:0] == 8'h00) ? x : {x[15:8], 8'hFF};
	endfunction
	function automatic logic [2:0] react(input int md);
		return md == 0 ? 3'b001 : md == 3 ? 3'b100 : 3'b010;
	endfunction
	initial begin
		{psel, penable, pwrite, send, slow, obstruction, reversing} = 0;
		paddr = 0; pwdata = 0; cmd = 0; function_block_logic = 0; srst = 1;
		{barrier_clear, operation_state, input1_pin, test_pulse} = 4'hF;
		door_opening_mm = 16'h01F4; dist_to_closed_mm = 16'h0032;
		void'($urandom(32'hA8667427));
		repeat (12) @(posedge clock);
		srst <= 0;
		apb(0, `OFS_FIELDBUS_MASK, 0); chk("fb mask", 32'hFFFF, r);
		apb(0, `OFS_FUNCTION_BLOCK_LOGIC_MASK, 0); chk("fl mask", 32'hFFFF, r);
		apb(0, 12'h0FC, 0); chk("slverr", 1, e);
		$display("reset and map done");
		for (int i = 0; i < 6; i++) begin
			v = i == 0 ? 16'h0001 : i == 1 ? 16'hFBFE : $urandom;
			apb(1, `OFS_FUNCTION_BLOCK_LOGIC_MASK, v);
			apb(0, `OFS_FUNCTION_BLOCK_LOGIC_MASK, 0); chk("low fix", fix(v[15:0]), r);
		end
		$display("mask write done");
		for (int i = 0; i < 8; i++) begin
			m = fix($urandom);
			w = $urandom;
			apb(1, `OFS_CONTROL, 32'h0330 | (i % 2) << 1);
			apb(1, i % 2 ? `OFS_FIELDBUS_MASK : `OFS_FUNCTION_BLOCK_LOGIC_MASK, m);
			send_cmd(w);
			chk("effective", w & m, effective_cmd);
			chk("profile", w[10] & m[10], second_force_profile);
			chk("code", w[7:0] & m[7:0], door_command_code);
		end
		$display("masking done");
		apb(1, `OFS_FIELDBUS_MASK, 32'hFFFF);
		for (int md = 0; md < 7; md++) begin
			if (md == 4 || md == 5) continue;
			apb(1, `OFS_CONTROL, 32'h0302 | md << 4);
			send_cmd(16'h0003);
			chk("close ok", 0, close_allowed);
			chk("reaction", react(md), {drive_open, ramp_stop, deenergize});
			chk("learn cancel", md == 0, learn_cancel);
		end
		apb(1, `OFS_CONTROL, 32'h0332);
		reversing <= 1; obstruction <= 1;
		send_cmd(16'h0003);
		chk("follow up", 1, follow_up_active);
		reversing <= 0; obstruction <= 0;
		apb(1, `OFS_RANGE, 32'h0010);
		repeat (3) @(posedge clock);
		chk("range", 1, close_allowed);
		apb(1, `OFS_RANGE, 32'hFFFF);
		repeat (3) @(posedge clock);
		chk("range back", 0, close_allowed);
		door_opening_mm <= 16'h0005;
		repeat (4) @(posedge clock);
		chk("small gap", 1, close_allowed);
		door_opening_mm <= 16'h01F4; operation_state <= 0;
		repeat (4) @(posedge clock);
		chk("not operating", 1, close_allowed);
		chk("test out on", 1, sensor_test_output);
		input1_pin <= 0; test_pulse <= 0;
		repeat (5) @(posedge clock);
		chk("curtain", 0, close_allowed);
		chk("test out", 0, sensor_test_output);
		$display("barrier done");
		apb(1, `OFS_CONTROL, 32'h0333);
		send_cmd(16'h0002); chk("test run", 1, test_run_active);
		obstruction <= 1;
		repeat (3) @(posedge clock);
		chk("hold force", 1, hold_force);
		obstruction <= 0;
		send_cmd(16'h0001); chk("test end", 0, test_run_active);
		chk("force released", 0, hold_force);
		$display("test run done");
		conclude;
	end
endmodule
`default_nettype wire
